// ==== hw/flash_host_pkg.sv ====
// Purpose: Shared constants and types for the parallel flash command controller.
// Assumes: 100 MHz ref_clk_i; byte-wide flash with 21 address lines.
// Notes: The host's own register map lives here beside the flash command codes.
package flash_host_pkg;

  localparam int CLK_NS = 10;
  localparam int ADDR_W = 21;

  // Write pulse width and read access time, in ns, with cycle counts rounded up.
  localparam int T_WP_NS = 45;
  localparam int T_ACC_NS = 70;
  localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);

  // Host register offsets.
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_PINCTRL = 3'h4;

  // Status and pin control field positions.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_TMO_BIT = 2;
  localparam int ST_RDATA_LSB = 8;
  localparam int PC_RST_BIT = 0;
  localparam int PC_HV_BIT = 1;

  // Operation codes written to the command register.
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_RESET1 = 4'h1;
  localparam logic [3:0] OP_RESET3 = 4'h2;
  localparam logic [3:0] OP_IDENT = 4'h3;
  localparam logic [3:0] OP_PROGRAM = 4'h4;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h5;
  localparam logic [3:0] OP_SECTOR_ERASE = 4'h6;
  localparam logic [3:0] OP_SUSPEND = 4'h7;
  localparam logic [3:0] OP_RESUME = 4'h8;

  // Flash command addresses and codes.
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 21'h005555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 21'h002aaa;
  localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_RESET = 8'hf0;
  localparam logic [7:0] CODE_IDENT = 8'h90;
  localparam logic [7:0] CODE_PROGRAM = 8'ha0;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_SUSPEND = 8'hb0;
  localparam logic [7:0] CODE_RESUME = 8'h30;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_W_SETUP,
    ST_W_PULSE,
    ST_W_HOLD,
    ST_R_PULSE,
    ST_R_END
  } state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] dq;
    logic dq_oe_n;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic rst_n;
    logic hv;
  } pins_t;

  localparam pins_t PINS_IDLE = '{addr: '0, dq: '0, dq_oe_n: 1'b1, ce_n: 1'b1,
                                  we_n: 1'b1, oe_n: 1'b1, rst_n: 1'b1, hv: 1'b0};

endpackage

// ==== hw/flash_host.sv ====
// Purpose: Host-side controller that drives a parallel flash through its strobes.
// Assumes: Flash pins are synchronous to ref_clk_i; software uses the simple register port.
// Notes: One operation at a time; commands arriving while busy are dropped.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
module flash_host
  import flash_host_pkg::*;
#(
  parameter logic [23:0] POLL_MAX = 24'hffffff
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic [7:0] flash_dq_o,
  input wire logic [7:0] flash_dq_i,
  output logic flash_dq_oe_n_o,
  output logic chip_select_n_o,
  output logic write_strobe_n_o,
  output logic output_gate_n_o,
  output logic flash_reset_n_o,
  output logic flash_hv_unprotect_o
);

  typedef struct packed {
    state_t st;
    logic [3:0] op;
    logic [2:0] step;
    logic [3:0] cnt;
    logic [23:0] polls;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [7:0] rdata;
    logic busy;
    logic done;
    logic tmo;
    logic rst_req;
    logic hv_req;
    pins_t pins;
    logic [31:0] rd_data;
  } ctl_t;

  ctl_t s;
  ctl_t next_s;

  function automatic logic [2:0] op_steps(input logic [3:0] op);
    case (op)
      OP_RESET1, OP_SUSPEND, OP_RESUME: op_steps = 3'd1;
      OP_RESET3, OP_IDENT: op_steps = 3'd3;
      OP_PROGRAM: op_steps = 3'd4;
      OP_CHIP_ERASE, OP_SECTOR_ERASE: op_steps = 3'd6;
      default: op_steps = 3'd0;
    endcase
  endfunction

  // Address and data of one write cycle within a command sequence.
  function automatic logic [ADDR_W+7:0] seq_word(input logic [3:0] op, input logic [2:0] step,
                                                 input logic [ADDR_W-1:0] a,
                                                 input logic [7:0] d);
    logic [7:0] third;
    third = CODE_RESET;
    case (op)
      OP_IDENT: third = CODE_IDENT;
      OP_PROGRAM: third = CODE_PROGRAM;
      OP_CHIP_ERASE, OP_SECTOR_ERASE: third = CODE_ERASE_SETUP;
      default: third = CODE_RESET;
    endcase
    case (step)
      3'd0: begin
        case (op)
          OP_RESET1: seq_word = {a, CODE_RESET};
          OP_SUSPEND: seq_word = {a, CODE_SUSPEND};
          OP_RESUME: seq_word = {a, CODE_RESUME};
          default: seq_word = {UNLOCK_ADDR1, CODE_UNLOCK1};
        endcase
      end
      3'd1: seq_word = {UNLOCK_ADDR2, CODE_UNLOCK2};
      3'd2: seq_word = {UNLOCK_ADDR1, third};
      3'd3: begin
        if (op == OP_PROGRAM) begin
          seq_word = {a, d};
        end else begin
          seq_word = {UNLOCK_ADDR1, CODE_UNLOCK1};
        end
      end
      3'd4: seq_word = {UNLOCK_ADDR2, CODE_UNLOCK2};
      3'd5: begin
        if (op == OP_CHIP_ERASE) begin
          seq_word = {UNLOCK_ADDR1, CODE_CHIP_ERASE};
        end else begin
          seq_word = {a, CODE_SECTOR_ERASE};
        end
      end
      default: seq_word = {UNLOCK_ADDR1, CODE_RESET};
    endcase
  endfunction

  logic [ADDR_W+7:0] word;
  logic is_poll_op;
  logic poll_ok;

  assign word = seq_word(s.op, s.step, s.addr, s.data);
  assign is_poll_op = (s.op == OP_PROGRAM) || (s.op == OP_CHIP_ERASE) ||
                      (s.op == OP_SECTOR_ERASE);
  // Program completes when the top bit echoes the written bit; erase when it reads one.
  assign poll_ok = (s.op == OP_PROGRAM) ? (s.rdata[7] == s.data[7]) : s.rdata[7];

  always_comb begin
    next_s = s;
    next_s.rd_data = '0;
    next_s.pins.rst_n = ~s.rst_req;
    next_s.pins.hv = s.hv_req;

    if (wr_i) begin
      case (addr_i)
        REG_CMD: begin
          if (!s.busy) begin
            next_s.op = wr_data_i[3:0];
            next_s.step = '0;
            next_s.cnt = '0;
            next_s.polls = '0;
            next_s.busy = 1'b1;
            next_s.done = 1'b0;
            next_s.tmo = 1'b0;
            next_s.st = (op_steps(wr_data_i[3:0]) == 3'd0) ? ST_R_PULSE : ST_W_SETUP;
          end
        end
        REG_ADDR: if (!s.busy) next_s.addr = wr_data_i[ADDR_W-1:0];
        REG_DATA: if (!s.busy) next_s.data = wr_data_i[7:0];
        REG_PINCTRL: begin
          next_s.rst_req = wr_data_i[PC_RST_BIT];
          next_s.hv_req = wr_data_i[PC_HV_BIT];
        end
        default: ;
      endcase
    end

    if (rd_i) begin
      case (addr_i)
        REG_CMD: next_s.rd_data = {28'h0000000, s.op};
        REG_ADDR: next_s.rd_data = {11'h000, s.addr};
        REG_DATA: next_s.rd_data = {24'h000000, s.data};
        REG_STATUS: begin
          next_s.rd_data[ST_BUSY_BIT] = s.busy;
          next_s.rd_data[ST_DONE_BIT] = s.done;
          next_s.rd_data[ST_TMO_BIT] = s.tmo;
          next_s.rd_data[ST_RDATA_LSB +: 8] = s.rdata;
        end
        REG_PINCTRL: begin
          next_s.rd_data[PC_RST_BIT] = s.rst_req;
          next_s.rd_data[PC_HV_BIT] = s.hv_req;
        end
        default: next_s.rd_data = '0;
      endcase
    end

    case (s.st)
      ST_IDLE: begin
        next_s.pins.ce_n = 1'b1;
        next_s.pins.we_n = 1'b1;
        next_s.pins.oe_n = 1'b1;
        next_s.pins.dq_oe_n = 1'b1;
      end
      // Address and data are set up a cycle before the write strobe falls.
      ST_W_SETUP: begin
        next_s.pins.addr = word[ADDR_W+7:8];
        next_s.pins.dq = word[7:0];
        next_s.pins.dq_oe_n = 1'b0;
        next_s.pins.oe_n = 1'b1;
        next_s.pins.ce_n = 1'b0;
        next_s.pins.we_n = 1'b1;
        next_s.cnt = '0;
        next_s.st = ST_W_PULSE;
      end
      ST_W_PULSE: begin
        next_s.pins.we_n = 1'b0;
        next_s.cnt = s.cnt + 4'd1;
        if (s.cnt == WP_CYC - 4'd1) begin
          next_s.st = ST_W_HOLD;
        end
      end
      // WE rises first with CE still low so the data edge is set by WE alone.
      ST_W_HOLD: begin
        if (!s.pins.we_n) begin
          next_s.pins.we_n = 1'b1;
        end else begin
          next_s.pins.ce_n = 1'b1;
          next_s.pins.dq_oe_n = 1'b1;
          if (s.step + 3'd1 < op_steps(s.op)) begin
            next_s.step = s.step + 3'd1;
            next_s.st = ST_W_SETUP;
          end else if (is_poll_op) begin
            // The pulse count must not shorten the access time of the first poll.
            next_s.cnt = '0;
            next_s.st = ST_R_PULSE;
          end else begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.st = ST_IDLE;
          end
        end
      end
      // Polls reuse the programmed or erased address so the top bit means completion.
      ST_R_PULSE: begin
        next_s.pins.addr = s.addr;
        next_s.pins.dq_oe_n = 1'b1;
        next_s.pins.we_n = 1'b1;
        next_s.pins.ce_n = 1'b0;
        next_s.pins.oe_n = 1'b0;
        next_s.cnt = s.cnt + 4'd1;
        if (s.cnt == ACC_CYC) begin
          next_s.rdata = flash_dq_i;
          next_s.cnt = '0;
          next_s.st = ST_R_END;
        end
      end
      ST_R_END: begin
        next_s.pins.ce_n = 1'b1;
        next_s.pins.oe_n = 1'b1;
        if (!is_poll_op || poll_ok) begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
          next_s.st = ST_IDLE;
        end else if (s.polls == POLL_MAX) begin
          // A program of a zero back to one may never complete; give up.
          next_s.busy = 1'b0;
          next_s.tmo = 1'b1;
          next_s.st = ST_IDLE;
        end else begin
          next_s.polls = s.polls + 24'd1;
          next_s.st = ST_R_PULSE;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase

    // Pulling the reset pin abandons the operation; the byte in flight is suspect.
    if (s.rst_req && s.busy) begin
      next_s.busy = 1'b0;
      next_s.tmo = 1'b1;
      next_s.st = ST_IDLE;
      next_s.pins.ce_n = 1'b1;
      next_s.pins.we_n = 1'b1;
      next_s.pins.oe_n = 1'b1;
      next_s.pins.dq_oe_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.pins <= PINS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o = s.rd_data;
  assign flash_addr_o = s.pins.addr;
  assign flash_dq_o = s.pins.dq;
  assign flash_dq_oe_n_o = s.pins.dq_oe_n;
  assign chip_select_n_o = s.pins.ce_n;
  assign write_strobe_n_o = s.pins.we_n;
  assign output_gate_n_o = s.pins.oe_n;
  assign flash_reset_n_o = s.pins.rst_n;
  assign flash_hv_unprotect_o = s.pins.hv;

endmodule // flash_host

// ==== verif/flash_host_properties.sv ====
// Purpose: Strobe timing and register port checks on the flash host.
// Assumes: Pulse and access lengths as chosen in the package.
// Notes: Bound to every flash_host instance.
`timescale 1ns/1ps
module flash_host_properties
  import flash_host_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_dq_oe_n_o,
  input wire logic chip_select_n_o,
  input wire logic write_strobe_n_o,
  input wire logic output_gate_n_o,
  input wire logic flash_hv_unprotect_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence pulse_s;
    (!write_strobe_n_o)[*5] ##1 write_strobe_n_o;
  endsequence
  sequence access_s;
    (!output_gate_n_o)[*7] ##[1:4] output_gate_n_o;
  endsequence
  write_gate_a:
    assert property (!write_strobe_n_o |-> !chip_select_n_o && output_gate_n_o)
    else $error("write strobe without select");
  read_gate_a:
    assert property (!output_gate_n_o |-> write_strobe_n_o && flash_dq_oe_n_o)
    else $error("read while writing");
  addr_hold_a:
    assert property (!write_strobe_n_o |-> $stable(flash_addr_o) && $stable(flash_dq_o))
    else $error("address or data moved in pulse");
  data_hold_a:
    assert property ($rose(write_strobe_n_o) |-> !chip_select_n_o && $stable(flash_dq_o))
    else $error("data not held at strobe rise");
  pulse_len_a:
    assert property ($fell(write_strobe_n_o) |-> pulse_s)
    else $error("write pulse length wrong");
  access_len_a:
    assert property ($fell(output_gate_n_o) |-> access_s)
    else $error("read access length wrong");
  rdata_idle_a:
    assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
    else $error("read data outside its cycle");
  hv_flag_a:
    assert property (wr_i && addr_i == REG_PINCTRL && wr_data_i[PC_HV_BIT]
      |-> ##[1:2] flash_hv_unprotect_o)
    else $error("unprotect flag not raised");
endmodule // flash_host_properties
bind flash_host flash_host_properties chk (.ref_clk_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_i,
  .rd_i, .rd_data_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_n_o, .chip_select_n_o,
  .write_strobe_n_o, .output_gate_n_o, .flash_hv_unprotect_o);

// ==== verif/flash_model.sv ====
// Purpose: Behavioural flash device behind the host controller.
// Assumes: Strobes arrive one at a time; no pin timing is checked here.
// Notes: Erase is instant; a program stays busy for two reads.
`timescale 1ns/1ps
module flash_model
  import flash_host_pkg::*;
#(
  // Identity values are arbitrary, picked with odd parity.
  parameter logic [7:0] MAKER_ID = 8'h13,
  parameter logic [7:0] PART_ID = 8'h8c,
  parameter logic [7:0] LOCKED = 8'h80
) (
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] dq_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic rst_n_i,
  input wire logic hv_i,
  output logic [7:0] dq_o
);
  logic [7:0] mem [int];
  logic [ADDR_W-1:0] la, pa;
  logic [7:0] pd, rdv;
  logic [7:0] rel = 8'h00;
  int step = 0;
  int busy = 0;
  logic ident = 1'b0;
  wire [10:0] lo = la[10:0];
  function automatic logic hit(input logic [10:0] a, input logic [7:0] d);
    return lo == a && dq_i == d;
  endfunction
  always @(negedge we_n_i or negedge ce_n_i) la = addr_i;
  always @(posedge we_n_i or posedge ce_n_i)
    if (oe_n_i && rst_n_i && (we_n_i ^ ce_n_i) && busy == 0) begin
      if (step == 3) begin
        if (!LOCKED[la[20:18]] || hv_i)
          mem[la] = (mem.exists(la) ? mem[la] : 8'hff) & dq_i;
        pa = la;
        pd = dq_i;
        busy = 2;
        step = 0;
      end else if (dq_i == CODE_RESET) begin
        step = 0;
        ident = 1'b0;
      end else if ((step == 0 || step == 4) && hit(11'h555, CODE_UNLOCK1)) step = step + 1;
      else if ((step == 1 || step == 5) && hit(11'h2aa, CODE_UNLOCK2)) step = step + 1;
      else if (step == 2 && hit(11'h555, CODE_IDENT)) begin
        ident = 1'b1;
        step = 0;
      end else if (step == 2 && hit(11'h555, CODE_PROGRAM)) step = 3;
      else if (step == 2 && hit(11'h555, CODE_ERASE_SETUP)) step = 4;
      else if (step == 6 && hit(11'h555, CODE_CHIP_ERASE)) begin
        mem.delete();
        step = 0;
      end else if (step == 6 && dq_i == CODE_SECTOR_ERASE) begin
        if (!LOCKED[la[20:18]] || hv_i)
          foreach (mem[k]) if (k[20:16] == la[20:16]) mem[k] = 8'hff;
        step = 0;
      end else step = 0;
    end
  always @(addr_i or oe_n_i or ce_n_i or busy or ident)
    if (busy > 0) rdv = {~pd[7], 7'h00};
    else if (ident && !addr_i[6])
      rdv = addr_i[1] ? {7'h00, LOCKED[addr_i[20:18]]} : (addr_i[0] ? PART_ID : MAKER_ID);
    else rdv = mem.exists(addr_i) ? mem[addr_i] : 8'hff;
  // A released bus shows the inverse of the last byte so stale data never passes.
  assign dq_o = (!ce_n_i && !oe_n_i && rst_n_i) ? rdv : rel;
  always @(posedge oe_n_i) begin
    rel <= ~rdv;
    // Blocking, so a reset pin falling in the same step sees the final count only if this block runs first.
    if (busy > 0) busy = busy - 1;
  end
  always @(negedge rst_n_i) begin
    if (busy > 0) mem[pa] = ~pd;
    busy = 0;
    step = 0;
    ident = 1'b0;
  end
endmodule // flash_model

// ==== verif/flash_host_tb_top.sv ====
// Purpose: Drives flash operations through the host registers and checks results.
// Assumes: Poll limit cut to four so failed programs end quickly.
// Notes: A program onto cleared or locked bits is expected to time out.
`timescale 1ns/1ps
module flash_host_tb_top
  import flash_host_pkg::*;
;
  // Identity values are arbitrary but need odd parity; the model is given the same ones.
  localparam logic [7:0] MAKER = 8'h13;
  localparam logic [7:0] PART = 8'h8c;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [31:0] wr_data_i = 32'h0;
  logic [31:0] rd_data_o, st;
  logic [ADDR_W-1:0] flash_addr_o;
  logic [7:0] flash_dq_o, flash_dq_i;
  logic flash_dq_oe_n_o, chip_select_n_o, write_strobe_n_o, output_gate_n_o;
  logic flash_reset_n_o, flash_hv_unprotect_o;
  int fails = 0;
  int checked = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  flash_host #(.POLL_MAX(24'h000004)) dut (.ref_clk_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_i,
    .rd_i, .rd_data_o, .flash_addr_o, .flash_dq_o, .flash_dq_i, .flash_dq_oe_n_o,
    .chip_select_n_o, .write_strobe_n_o, .output_gate_n_o, .flash_reset_n_o,
    .flash_hv_unprotect_o);
  flash_model #(.MAKER_ID(MAKER), .PART_ID(PART), .LOCKED(8'h80)) dev (.addr_i(flash_addr_o),
    .dq_i(flash_dq_o), .ce_n_i(chip_select_n_o), .we_n_i(write_strobe_n_o),
    .oe_n_i(output_gate_n_o), .rst_n_i(flash_reset_n_o), .hv_i(flash_hv_unprotect_o),
    .dq_o(flash_dq_i));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    st = rd_data_o;
  endtask
  task automatic op(input logic [3:0] c, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wr(REG_ADDR, 32'(a));
    wr(REG_DATA, 32'(d));
    wr(REG_CMD, 32'(c));
    do begin
      rd(REG_STATUS);
      n++;
    end while (st[ST_BUSY_BIT] !== 1'b0 && n < 300);
    check("op busy", 32'(st[ST_BUSY_BIT]), 32'h0);
  endtask
  task automatic fread(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    op(OP_READ, a, 8'h00);
    check("read byte", 32'(st[15:8]), 32'(exp));
  endtask
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    fails++;
    results();
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(REG_STATUS);
    check("reset status", st, 32'h0);
    rd(3'h7);
    check("unmapped", st, 32'h0);
    fread(21'h000100, 8'hff);
    op(OP_PROGRAM, 21'h000100, 8'h3c);
    check("program", 32'(st[2:0]), 32'h2);
    fread(21'h000100, 8'h3c);
    op(OP_PROGRAM, 21'h000100, 8'hc3);
    check("set bits", 32'(st[ST_TMO_BIT]), 32'h1);
    fread(21'h000100, 8'h00);
    op(OP_IDENT, 21'h000000, 8'h00);
    fread(21'h000000, MAKER);
    check("maker parity", 32'(^st[15:8]), 32'h1);
    fread(21'h000001, PART);
    check("part parity", 32'(^st[15:8]), 32'h1);
    fread(21'h1c0002, 8'h01);
    fread(21'h000002, 8'h00);
    op(OP_RESET3, 21'h000000, 8'h00);
    fread(21'h000100, 8'h00);
    op(OP_IDENT, 21'h000000, 8'h00);
    op(OP_RESET1, 21'h023456, 8'h00);
    fread(21'h000100, 8'h00);
    op(OP_PROGRAM, 21'h1c0000, 8'h12);
    check("locked", 32'(st[ST_TMO_BIT]), 32'h1);
    fread(21'h1c0000, 8'hff);
    wr(REG_PINCTRL, 32'h2);
    rd(REG_PINCTRL);
    check("pin control", st, 32'h2);
    op(OP_PROGRAM, 21'h1c0000, 8'h12);
    check("unlocked", 32'(st[2:0]), 32'h2);
    wr(REG_PINCTRL, 32'h0);
    fread(21'h1c0000, 8'h12);
    op(OP_SUSPEND, 21'h000000, 8'h00);
    check("suspend", 32'(st[2:0]), 32'h2);
    op(OP_RESUME, 21'h000000, 8'h00);
    check("resume", 32'(st[2:0]), 32'h2);
    op(OP_CHIP_ERASE, 21'h000000, 8'h00);
    check("erase", 32'(st[2:0]), 32'h2);
    fread(21'h000100, 8'hff);
    op(OP_PROGRAM, 21'h010005, 8'h5a);
    op(OP_SECTOR_ERASE, 21'h01ffff, 8'h00);
    check("sector erase", 32'(st[2:0]), 32'h2);
    fread(21'h010005, 8'hff);
    wr(REG_ADDR, 32'h200);
    wr(REG_DATA, 32'h0);
    wr(REG_CMD, 32'(OP_PROGRAM));
    // The reset pin falls as the first poll ends, so no strobe is cut short
    // while the device is still programming.
    repeat (38) @(posedge ref_clk_i);
    wr(REG_PINCTRL, 32'h1);
    repeat (2) @(negedge ref_clk_i);
    check("reset pin", 32'(flash_reset_n_o), 32'h0);
    wr(REG_PINCTRL, 32'h0);
    rd(REG_STATUS);
    check("abort", 32'(st[ST_TMO_BIT]), 32'h1);
    check("reset pin released", 32'(flash_reset_n_o), 32'h1);
    results();
  end
endmodule // flash_host_tb_top
